// ==== hdl/dbig_map.svh ====
/*
 * register offsets, field positions and reset values for the display bus glue.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DBIG_MAP_SVH
`define DBIG_MAP_SVH

// i/o port addresses (10 decoded address bits)
`define DBIG_PORT_MISC      10'h3C2
`define DBIG_PORT_MONO_STAT 10'h3BA
`define DBIG_PORT_COL_STAT  10'h3DA
`define DBIG_PORT_MONO_CRTA 10'h3B4
`define DBIG_PORT_COL_CRTA  10'h3D4
`define DBIG_PORT_MONO_CRTD 10'h3B5
`define DBIG_PORT_COL_CRTD  10'h3D5
`define DBIG_PORT_PEN_SET_C 10'h3DC
`define DBIG_PORT_PEN_SET_M 10'h3B9
`define DBIG_PORT_PEN_CLR_C 10'h3DB
`define DBIG_PORT_PEN_CLR_M 10'h3BB
// crtc index of the emulation mode register
`define DBIG_IDX_EMU        8'hFF
`define DBIG_IDX_RST        8'h00

// reset values
`define DBIG_MISC_RST       8'h00
`define DBIG_FEAT_RST       8'h00
`define DBIG_EMU_RST        8'h00

// field positions
`define DBIG_MISC_SEL_LO    2
`define DBIG_MISC_SEL_HI    3
`define DBIG_EMU_MODE_LO    0
`define DBIG_EMU_MODE_HI    1
`define DBIG_IS0_SWITCH     4
`define DBIG_IS0_FEAT0      5
`define DBIG_IS0_FEAT1      6
`define DBIG_IS1_PEN_LATCH  1
`define DBIG_IS1_PEN_SW     2
`define DBIG_MONO_HRT       0
`define DBIG_MONO_VID       3
`define DBIG_MONO_VRT       7
`define DBIG_COL_VRT        3
`define DBIG_FEAT_OUT0      0
`define DBIG_FEAT_OUT1      1

// memory decode
`define DBIG_DISP_SEG       3'h5
`define DBIG_ROM_SEG        6'h30
// i/o pages holding the register groups (address bits 9..4)
`define DBIG_IO_BLK_MONO    6'h3B
`define DBIG_IO_BLK_ENH     6'h3C
`define DBIG_IO_BLK_COL     6'h3D

`endif

// ==== hdl/dbig_pkg.sv ====
/*
 * types shared by the display bus glue.
 * defines its own mode encodings; assumes they match the emulation mode field of the map header.
 */
package dbig_pkg;
    // emulation mode selects which status layout appears at the status ports
    typedef enum logic [1:0] {
        DBIG_MODE_ENHANCED = 2'b00,
        DBIG_MODE_COLOUR = 2'b01,
        DBIG_MODE_MONO = 2'b10,
        DBIG_MODE_RSVD = 2'b11
    } dbig_mode_t;
endpackage : dbig_pkg

// ==== hdl/dbig_sync3.sv ====
/*
 * three-flop input synchroniser; the output changes once stages two and three agree.
 * assumes an asynchronous input and one clock.
 */
`timescale 1ns/1ps
module dbig_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // signal
    input wire logic i_async,
    output logic o_sync
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;
    // first stage is read only by the second
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            out_reg <= RST_VAL;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                out_reg <= s3_reg;
            end
        end
    end
    assign o_sync = out_reg;
endmodule : dbig_sync3

// ==== hdl/dbig_top.sv ====
/*
 * display bus glue: memory window decode, rom enables, local data transceiver,
 * status assembly, feature control and light pen latch.
 * assumes i_ref_clk is the expansion bus clock, bus strobes are active low
 * pins, and the controller drives the local bus on reads it owns.
 */
`timescale 1ns/1ps
`include "dbig_map.svh"
module dbig_top
    import dbig_pkg::*;
(
    // clock and resets
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sys_reset,
    // system bus control
    input wire logic [19:0] i_sys_addr,
    input wire logic i_aen,
    input wire logic i_memr_n,
    input wire logic i_memw_n,
    input wire logic i_ior_n,
    input wire logic i_iow_n,
    input wire logic i_dack_n,
    // system data bus
    input wire logic [7:0] i_sys_data,
    output logic [7:0] o_sys_data,
    output logic o_sys_data_oe,
    // local data bus
    input wire logic [7:0] i_local_data,
    output logic [7:0] o_local_data,
    output logic o_local_data_oe,
    // memory decode
    output logic o_display_mem_select_n,
    output logic o_buffered_addr_bit16,
    output logic o_rom_write_enable_n,
    output logic o_rom_output_enable_n,
    // light pen
    input wire logic i_pen_trigger_in,
    input wire logic i_pen_switch_in,
    output logic o_pen_capture_strobe,
    // feature connector and switches
    input wire logic i_feature_code_in_0,
    input wire logic i_feature_code_in_1,
    output logic o_feature_ctl_out_0,
    output logic o_feature_ctl_out_1,
    input wire logic i_switch_sense,
    output logic o_switch_select_0,
    output logic o_switch_select_1,
    // controller video status
    input wire logic i_hretrace_in,
    input wire logic i_vretrace_in,
    input wire logic i_sec_blue_mono_video_in
);

    // synchronised pins
    logic iow_n_s;
    logic pen_trig_s;
    logic pen_sw_s;
    logic feat0_s;
    logic feat1_s;
    logic switch_s;
    logic hrt_s;
    logic vrt_s;
    logic vid_s;

    dbig_sync3 #(.RST_VAL(1'b1)) u_sync_iow (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_iow_n), .o_sync(iow_n_s)
    );
    dbig_sync3 #(.RST_VAL(1'b1)) u_sync_pen (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_pen_trigger_in),
        .o_sync(pen_trig_s)
    );
    dbig_sync3 #(.RST_VAL(1'b1)) u_sync_psw (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_pen_switch_in),
        .o_sync(pen_sw_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_f0 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_feature_code_in_0),
        .o_sync(feat0_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_f1 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_feature_code_in_1),
        .o_sync(feat1_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_sw (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_switch_sense),
        .o_sync(switch_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_hrt (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_hretrace_in), .o_sync(hrt_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_vrt (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_vretrace_in), .o_sync(vrt_s)
    );
    dbig_sync3 #(.RST_VAL(1'b0)) u_sync_vid (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_async(i_sec_blue_mono_video_in),
        .o_sync(vid_s)
    );

    // registers
    logic [7:0] misc_output_control_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] emulation_mode_control_reg;
    logic [7:0] crtc_index_reg;
    logic pen_latch_reg;
    logic pen_strobe_reg;
    logic pen_prev_reg;
    logic iow_prev_reg;
    logic [7:0] sys_data_reg;
    logic [7:0] local_data_reg;

    // memory decode; strobes gated by dma acknowledge
    wire mem_rd = !i_memr_n && i_dack_n;
    wire mem_wr = !i_memw_n && i_dack_n;
    wire disp_hit = (i_sys_addr[19:17] == `DBIG_DISP_SEG);
    wire rom_hit = (i_sys_addr[19:14] == `DBIG_ROM_SEG);
    assign o_display_mem_select_n = !disp_hit;
    assign o_buffered_addr_bit16 = i_sys_addr[16];
    assign o_rom_write_enable_n = !(mem_wr && rom_hit);
    assign o_rom_output_enable_n = !(mem_rd && rom_hit);

    // i/o decode; address enable means a dma cycle owns the bus
    wire [9:0] io_addr = i_sys_addr[9:0];
    wire io_ok = !i_aen;
    wire io_rd = io_ok && !i_ior_n;
    // write acts once, on the synchronised falling edge of the strobe
    wire io_wr = io_ok && iow_prev_reg && !iow_n_s;
    dbig_mode_t mode;
    assign mode = dbig_mode_t'(emulation_mode_control_reg[`DBIG_EMU_MODE_HI:`DBIG_EMU_MODE_LO]);
    wire is_mono = (mode == DBIG_MODE_MONO);
    wire is_col = (mode == DBIG_MODE_COLOUR);
    wire hit_misc = (io_addr == `DBIG_PORT_MISC);
    wire hit_stat = (io_addr == `DBIG_PORT_MONO_STAT) || (io_addr == `DBIG_PORT_COL_STAT);
    wire hit_crta = (io_addr == `DBIG_PORT_MONO_CRTA) || (io_addr == `DBIG_PORT_COL_CRTA);
    wire hit_crtd = (io_addr == `DBIG_PORT_MONO_CRTD) || (io_addr == `DBIG_PORT_COL_CRTD);
    wire hit_emu = hit_crtd && (crtc_index_reg == `DBIG_IDX_EMU);
    wire hit_pset = is_mono ? (io_addr == `DBIG_PORT_PEN_SET_M)
                            : (io_addr == `DBIG_PORT_PEN_SET_C);
    wire hit_pclr = is_mono ? (io_addr == `DBIG_PORT_PEN_CLR_M)
                            : (io_addr == `DBIG_PORT_PEN_CLR_C);
    // colour mode also treats reads of the set/clear ports as triggers
    wire io_rd_edge = io_rd && is_col;
    wire sw_set = hit_pset && io_wr;
    wire sw_clr = hit_pclr && io_wr;

    // light pen edge from two successive synchronised samples
    wire pen_fall = pen_prev_reg && !pen_trig_s;

    // status assembly
    logic [7:0] stat0;
    logic [7:0] stat1;
    always_comb begin
        stat0 = 8'h00;
        stat0[`DBIG_IS0_SWITCH] = switch_s;
        stat0[`DBIG_IS0_FEAT0] = feat0_s;
        stat0[`DBIG_IS0_FEAT1] = feat1_s;
        stat1 = 8'h00;
        stat1[`DBIG_IS1_PEN_LATCH] = pen_latch_reg;
        stat1[`DBIG_IS1_PEN_SW] = pen_sw_s;
        case (mode)
            DBIG_MODE_MONO: begin
                stat1[`DBIG_MONO_HRT] = hrt_s;
                stat1[`DBIG_MONO_VID] = vid_s;
                stat1[`DBIG_MONO_VRT] = vrt_s;
            end
            DBIG_MODE_COLOUR: begin
                stat1[`DBIG_COL_VRT] = vrt_s;
            end
            default: begin
                stat1[`DBIG_COL_VRT] = vrt_s;
            end
        endcase
    end

    // read data: own registers drive the system bus, else local bus passes through
    wire own_rd = hit_misc || hit_stat || hit_emu;
    wire [7:0] own_data = hit_misc ? stat0 :
                          hit_stat ? stat1 : emulation_mode_control_reg;
    // drive the system bus only for cycles of this subsystem, so other cards never collide
    // limitation: controller registers outside these three pages are not passed through
    wire io_page = (io_addr[9:4] == `DBIG_IO_BLK_MONO) || (io_addr[9:4] == `DBIG_IO_BLK_ENH) ||
                   (io_addr[9:4] == `DBIG_IO_BLK_COL);
    wire mem_page = disp_hit || rom_hit;
    wire rd_any = (io_rd && io_page) || (mem_rd && mem_page);
    wire [7:0] rd_data = (io_rd && own_rd) ? own_data : i_local_data;
    assign o_sys_data = sys_data_reg;
    assign o_sys_data_oe = rd_any;
    // local bus driven toward controller and rom on writes only
    assign o_local_data = local_data_reg;
    assign o_local_data_oe = !rd_any && ((io_ok && !i_iow_n) || mem_wr);

    // switch select and feature outputs straight from registers
    assign o_switch_select_0 = misc_output_control_reg[`DBIG_MISC_SEL_LO];
    assign o_switch_select_1 = misc_output_control_reg[`DBIG_MISC_SEL_HI];
    assign o_feature_ctl_out_0 = feature_control_reg[`DBIG_FEAT_OUT0];
    assign o_feature_ctl_out_1 = feature_control_reg[`DBIG_FEAT_OUT1];
    assign o_pen_capture_strobe = pen_strobe_reg;

    // per-register write strobes; system reset outranks a write in the same cycle
    wire wr_misc = io_wr && hit_misc;
    wire wr_feat = io_wr && hit_stat;
    wire wr_emu = io_wr && hit_emu;
    wire wr_index = io_wr && hit_crta;

    // miscellaneous output register; system reset acts synchronously on the bus clock
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            misc_output_control_reg <= `DBIG_MISC_RST;
        end else if (i_sys_reset) begin
            misc_output_control_reg <= `DBIG_MISC_RST;
        end else if (wr_misc) begin
            misc_output_control_reg <= i_sys_data;
        end
    end

    // feature control register, written through either status port
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            feature_control_reg <= `DBIG_FEAT_RST;
        end else if (i_sys_reset) begin
            feature_control_reg <= `DBIG_FEAT_RST;
        end else if (wr_feat) begin
            feature_control_reg <= i_sys_data;
        end
    end

    // emulation mode register; only crtc index 0xFF reaches it,
    // so writes to the controller's own crtc registers leave the mode alone
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            emulation_mode_control_reg <= `DBIG_EMU_RST;
        end else if (i_sys_reset) begin
            emulation_mode_control_reg <= `DBIG_EMU_RST;
        end else if (wr_emu) begin
            emulation_mode_control_reg <= i_sys_data;
        end
    end

    // crtc index; cleared with the rest so a stale index cannot alias the mode register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crtc_index_reg <= `DBIG_IDX_RST;
        end else if (i_sys_reset) begin
            crtc_index_reg <= `DBIG_IDX_RST;
        end else if (wr_index) begin
            crtc_index_reg <= i_sys_data;
        end
    end

    // light pen latch: set wins over clear, only software clears
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pen_latch_reg <= 1'b0;
            pen_strobe_reg <= 1'b0;
            pen_prev_reg <= 1'b1;
            iow_prev_reg <= 1'b1;
        end else begin
            pen_prev_reg <= pen_trig_s;
            iow_prev_reg <= iow_n_s;
            if (pen_fall || sw_set || (io_rd_edge && hit_pset)) begin
                pen_latch_reg <= 1'b1;
            end else if (sw_clr || (io_rd_edge && hit_pclr)) begin
                pen_latch_reg <= 1'b0;
            end
            pen_strobe_reg <= pen_fall ? 1'b1 : !pen_trig_s && pen_strobe_reg;
        end
    end

    // data registers follow the selected source each cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_data_reg <= 8'h00;
            local_data_reg <= 8'h00;
        end else begin
            sys_data_reg <= rd_data;
            local_data_reg <= i_sys_data;
        end
    end

endmodule : dbig_top

// ==== tb/dbig_assertions.sv ====
/* port checker for the display bus glue.
   assumes binding onto dbig_top and a single bus clock. */
`timescale 1ns/1ps
module dbig_assertions (
    // clock and resets
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sys_reset,
    // bus side
    input wire logic [19:0] i_sys_addr,
    input wire logic i_aen,
    input wire logic i_memr_n,
    input wire logic i_memw_n,
    input wire logic i_iow_n,
    input wire logic i_dack_n,
    input wire logic o_sys_data_oe,
    // decode and pins
    input wire logic o_display_mem_select_n,
    input wire logic o_buffered_addr_bit16,
    input wire logic o_rom_write_enable_n,
    input wire logic o_rom_output_enable_n,
    input wire logic i_pen_trigger_in,
    input wire logic o_pen_capture_strobe,
    input wire logic o_feature_ctl_out_0,
    input wire logic o_feature_ctl_out_1,
    input wire logic o_switch_select_0,
    input wire logic o_switch_select_1
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // rom window c0000-c3fff
    wire logic rom_hit = i_sys_addr[19:14] == 6'h30;
    wire logic [1:0] feat_w = {o_feature_ctl_out_1, o_feature_ctl_out_0};

    a_disp_select: assert property (
        o_display_mem_select_n == (i_sys_addr[19:17] != 3'h5))
        else $error("display select wrong");
    a_addr_buffer: assert property (o_buffered_addr_bit16 == i_sys_addr[16])
        else $error("address bit 16 wrong");
    a_rom_write: assert property (
        o_rom_write_enable_n == !(!i_memw_n && i_dack_n && rom_hit))
        else $error("rom write enable wrong");
    a_rom_read: assert property (
        o_rom_output_enable_n == !(!i_memr_n && i_dack_n && rom_hit))
        else $error("rom output enable wrong");
    a_aen_no_read: assert property (i_aen && i_memr_n |-> !o_sys_data_oe)
        else $error("read driven during dma");
    a_sys_reset_clear: assert property (i_sys_reset ##1 i_sys_reset |=>
        feat_w == 2'b00 && !o_switch_select_0 && !o_switch_select_1)
        else $error("system reset did not clear");
    // a change without a reset must follow a write strobe seen low a few edges earlier
    a_write_synced: assert property ($changed(feat_w) && !$past(i_sys_reset) &&
        !$past(i_sys_reset, 2) |-> !$past(i_iow_n, 3))
        else $error("feature change without synced write");
    a_pen_strobe: assert property ($fell(i_pen_trigger_in) ##1 (!i_pen_trigger_in) [*8]
        |-> o_pen_capture_strobe)
        else $error("pen strobe missing");
    a_pen_sampled: assert property (
        $rose(o_pen_capture_strobe) |-> !$past(i_pen_trigger_in, 3))
        else $error("pen strobe too early");
    c_pen: cover property ($fell(i_pen_trigger_in));
    c_rom_wr: cover property (!o_rom_write_enable_n);
    c_dack: cover property (!i_dack_n && !i_memr_n);
    c_reset: cover property (i_sys_reset);
endmodule : dbig_assertions

bind dbig_top dbig_assertions dbig_assertions_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_sys_reset(i_sys_reset), .i_sys_addr(i_sys_addr), .i_aen(i_aen), .i_memr_n(i_memr_n),
    .i_memw_n(i_memw_n), .i_iow_n(i_iow_n), .i_dack_n(i_dack_n), .o_sys_data_oe(o_sys_data_oe),
    .o_display_mem_select_n(o_display_mem_select_n), .o_buffered_addr_bit16(o_buffered_addr_bit16),
    .o_rom_write_enable_n(o_rom_write_enable_n), .o_rom_output_enable_n(o_rom_output_enable_n),
    .i_pen_trigger_in(i_pen_trigger_in), .o_pen_capture_strobe(o_pen_capture_strobe),
    .o_feature_ctl_out_0(o_feature_ctl_out_0), .o_feature_ctl_out_1(o_feature_ctl_out_1),
    .o_switch_select_0(o_switch_select_0), .o_switch_select_1(o_switch_select_1));

// ==== tb/dbig_far_model.sv ====
/* local side model: the bios rom answering on the local data bus.
   assumes the bench merges its output with the glue's own drive. */
`timescale 1ns/1ps
module dbig_far_model (
    // clock and address
    input wire logic i_ref_clk,
    input wire logic [19:0] i_sys_addr,
    input wire logic i_rom_output_enable_n,
    // local bus drive
    output logic [7:0] o_local_data
);
    logic [7:0] idle_reg = 8'h00;
    // a released bus toggles so a stale byte can never pass for read data
    always_ff @(posedge i_ref_clk) begin
        idle_reg <= ~idle_reg;
    end
    // rom byte is a fixed function of the address
    assign o_local_data = !i_rom_output_enable_n ? (i_sys_addr[7:0] ^ 8'h5A) : idle_reg;
endmodule : dbig_far_model

// ==== tb/dbig_top_bench.sv ====
/* self-checking bench for the display bus glue.
   assumes the far model on the local bus and the bound port checker. */
`timescale 1ns/1ps
module dbig_top_bench;
    logic clk = 0, rst_n = 0, srst = 0, aen = 0, memr_n = 1, memw_n = 1, ior_n = 1, iow_n = 1;
    logic dack_n = 1, ptrig = 1, psw = 1, fc0 = 1, fc1 = 0, sw = 1, hr = 0, vr = 0, bv = 0;
    logic [19:0] addr = 20'h00000;
    logic [7:0] wd = 8'h00, rd, ld_o, far_d, lbus;
    logic rd_oe, ld_oe, dsel_n, a16, we_n, oe_n, pstb, fo0, fo1, ss0, ss1;
    int failures = 0, checks_done = 0;
    logic [19:0] tbl [6] = '{20'h9FFFF, 20'hA0000, 20'hBFFFF, 20'hC0000, 20'hC3FFF, 20'hC4000};
    // the local wire: glue drives on writes, the rom model otherwise
    assign lbus = ld_oe ? ld_o : far_d;
    dbig_top dbig_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sys_reset(srst), .i_sys_addr(addr),
        .i_aen(aen), .i_memr_n(memr_n), .i_memw_n(memw_n), .i_ior_n(ior_n), .i_iow_n(iow_n),
        .i_dack_n(dack_n), .i_sys_data(wd), .o_sys_data(rd), .o_sys_data_oe(rd_oe),
        .i_local_data(lbus), .o_local_data(ld_o), .o_local_data_oe(ld_oe),
        .o_display_mem_select_n(dsel_n), .o_buffered_addr_bit16(a16),
        .o_rom_write_enable_n(we_n), .o_rom_output_enable_n(oe_n), .i_pen_trigger_in(ptrig),
        .i_pen_switch_in(psw), .o_pen_capture_strobe(pstb), .i_feature_code_in_0(fc0),
        .i_feature_code_in_1(fc1), .o_feature_ctl_out_0(fo0), .o_feature_ctl_out_1(fo1),
        .i_switch_sense(sw), .o_switch_select_0(ss0), .o_switch_select_1(ss1),
        .i_hretrace_in(hr), .i_vretrace_in(vr), .i_sec_blue_mono_video_in(bv));
    dbig_far_model dbig_far_model_i (.i_ref_clk(clk), .i_sys_addr(addr),
        .i_rom_output_enable_n(oe_n), .o_local_data(far_d));
    // 25 mhz bus clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // write strobe held long enough for the three-flop synchroniser
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        addr = {10'h000, a};
        wd = d;
        iow_n = 0;
        cyc(6);
        iow_n = 1;
        cyc(6);
    endtask : io_wr
    task automatic rdchk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
        addr = {10'h000, a};
        ior_n = 0;
        cyc(3);
        chk(rd & m, e);
        chk(rd_oe, 8'h01);
        ior_n = 1;
        cyc(2);
    endtask : rdchk
    // one write then one read at an address, with or without dma acknowledge
    task automatic mem(input logic [19:0] a, input logic dk);
        logic rom;
        logic own;
        rom = a[19:14] == 6'h30 && dk;
        own = (a[19:17] == 3'h5 || a[19:14] == 6'h30) && dk;
        addr = a;
        dack_n = dk;
        wd = a[7:0];
        memw_n = 0;
        cyc(2);
        chk({dsel_n, a16, we_n, oe_n}, {a[19:17] != 3'b101, a[16], !rom, 1'b1});
        chk(ld_o, a[7:0]);
        chk(ld_oe, dk);
        memw_n = 1;
        cyc(1);
        memr_n = 0;
        cyc(2);
        chk({we_n, oe_n}, {1'b1, !rom});
        chk(rd_oe, own);
        if (rom) chk(rd, a[7:0] ^ 8'h5A);
        memr_n = 1;
        dack_n = 1;
        cyc(1);
    endtask : mem
    // hang guard
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        $display("[FAIL] %0t run did not finish", $time);
        conclude();
    end
    initial begin
        cyc(10);
        rst_n = 1;
        cyc(6);
        chk({ss1, ss0, fo1, fo0}, 8'h00);
        rdchk(10'h3C2, 8'h70, 8'h30);
        {fc0, fc1, sw} = 3'b010;
        cyc(6);
        rdchk(10'h3C2, 8'h70, 8'h40);
        io_wr(10'h3C2, 8'h0C);
        chk({ss1, ss0}, 8'h03);
        io_wr(10'h3BA, 8'h03);
        chk({fo1, fo0}, 8'h03);
        io_wr(10'h3DA, 8'h02);
        chk({fo1, fo0}, 8'h02);
        $display("registers done");
        aen = 1;
        io_wr(10'h3BA, 8'h01);
        chk({fo1, fo0}, 8'h02);
        ior_n = 0;
        cyc(2);
        chk(rd_oe, 8'h00);
        ior_n = 1;
        aen = 0;
        cyc(2);
        $display("dma done");
        io_wr(10'h3B4, 8'hFF);
        io_wr(10'h3B5, 8'h02);
        for (int k = 0; k < 2; k++) begin
            {hr, vr, bv} = k[0] ? 3'b101 : 3'b010;
            cyc(6);
            rdchk(10'h3BA, 8'h89, {vr, 3'b000, bv, 2'b00, hr});
        end
        io_wr(10'h3D4, 8'hFF);
        io_wr(10'h3D5, 8'h01);
        for (int k = 0; k < 2; k++) begin
            vr = k[0];
            cyc(6);
            rdchk(10'h3DA, 8'h08, {4'h0, vr, 3'b000});
        end
        rdchk(10'h3D5, 8'hFF, 8'h01);
        $display("modes done");
        srst = 1;
        cyc(2);
        srst = 0;
        cyc(6);
        chk({ss1, ss0, fo1, fo0}, 8'h00);
        rdchk(10'h3C2, 8'h70, 8'h40);
        io_wr(10'h3D4, 8'hFF);
        rdchk(10'h3D5, 8'hFF, 8'h00);
        $display("system reset done");
        rdchk(10'h3BA, 8'h06, 8'h04);
        psw = 0;
        ptrig = 0;
        cyc(10);
        chk(pstb, 8'h01);
        ptrig = 1;
        cyc(8);
        chk(pstb, 8'h00);
        rdchk(10'h3BA, 8'h06, 8'h02);
        io_wr(10'h3DB, 8'h00);
        rdchk(10'h3BA, 8'h02, 8'h00);
        io_wr(10'h3DC, 8'h00);
        rdchk(10'h3BA, 8'h02, 8'h02);
        $display("light pen done");
        foreach (tbl[i]) begin
            mem(tbl[i], 1'b1);
            mem(tbl[i], 1'b0);
        end
        $display("memory decode done");
        conclude();
    end
endmodule : dbig_top_bench
